/* File: core/bwp_defs.vh */
`ifndef BWP_DEFS_VH
`define BWP_DEFS_VH
`define BWP_CTRL_CODE 4'h6
`define BWP_SEL_BLK0 3'h1
`define BWP_SEL_BLK1 3'h4
`define BWP_SEL_BLK2 3'h5
`define BWP_SEL_BLK3 3'h0
`define BWP_SEL_CLEAR 3'h3
`define BWP_NUM_BLOCKS 4
`define BWP_DUMMY_BYTES 2'h2
`define BWP_WRITE_TIME_US 5000
`define BWP_CLK_MHZ 50
`define BWP_WRITE_CYCLES (`BWP_WRITE_TIME_US * `BWP_CLK_MHZ)
`endif

/* File: core/bwp_flag_store.v */
`timescale 1ns/1ps
`include "bwp_defs.vh"
// protection flags; stands in for the nonvolatile cells, read data registered
module bwp_flag_store (
   input wire mclk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire [3:0] init_flags_in,
   input wire load_init_in,
   input wire commit_in,
   input wire clear_all_in,
   input wire [3:0] set_mask_in,
   output reg [3:0] flags_out
);
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_out <= 4'h0;
      end else if (ce_in) begin
         if (load_init_in) begin
            flags_out <= init_flags_in;
         end else if (commit_in) begin
            if (clear_all_in) begin
               flags_out <= 4'h0;
            end else begin
               flags_out <= flags_out | set_mask_in;
            end
         end
      end
   end
endmodule // bwp_flag_store

/* File: core/bwp_protect_ctrl.v */
`timescale 1ns/1ps
`include "bwp_defs.vh"
module bwp_protect_ctrl #(
   parameter WRITE_CYCLES = `BWP_WRITE_CYCLES
) (
   input wire mclk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire scl_in,
   input wire sda_in,
   input wire high_voltage_level_in,
   input wire [3:0] init_flags_in,
   input wire [8:0] array_addr_in,
   output reg sda_out,
   output reg sda_oe_n_out,
   output reg [3:0] protect_flags_out,
   output reg addr_protected_out,
   output reg write_busy_out
);
   localparam ST_IDLE = 4'h1;
   localparam ST_CTRL = 4'h2;
   localparam ST_DUMMY = 4'h4;
   localparam ST_QUERY = 4'h8;
   localparam [31:0] WR_LOAD = WRITE_CYCLES;

   // one-hot decode of the select bits to a block mask
   function [3:0] blk_mask;
      input [2:0] sel;
      begin
         case (sel)
            `BWP_SEL_BLK0: blk_mask = 4'h1;
            `BWP_SEL_BLK1: blk_mask = 4'h2;
            `BWP_SEL_BLK2: blk_mask = 4'h4;
            `BWP_SEL_BLK3: blk_mask = 4'h8;
            default: blk_mask = 4'h0;
         endcase
      end
   endfunction

   reg [1:0] scl_s_q;
   reg [1:0] sda_s_q;
   reg [1:0] hv_s_q;
   reg scl_d1_q;
   reg sda_d1_q;
   reg [3:0] state_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg ack_phase_q;
   reg ack_give_q;
   reg [1:0] dummy_cnt_q;
   reg is_clear_q;
   reg [3:0] mask_q;
   reg armed_q;
   reg hv_ok_q;
   reg [31:0] wr_cnt_q;
   reg init_done_q;
   reg commit_q;
   wire [3:0] flags;

   // edge and condition finders on the synchronised pins
   wire scl_rise = scl_s_q[1] & ~scl_d1_q;
   wire scl_fall = ~scl_s_q[1] & scl_d1_q;
   wire start_c = scl_s_q[1] & scl_d1_q & sda_d1_q & ~sda_s_q[1];
   wire stop_c = scl_s_q[1] & scl_d1_q & ~sda_d1_q & sda_s_q[1];
   wire [7:0] byte_w = {shift_q[6:0], sda_s_q[1]};
   wire busy = wr_cnt_q != 32'h0;

   // control byte decode, valid on the eighth rising clock
   wire code_ok = byte_w[7:4] == `BWP_CTRL_CODE;
   wire sel_clear = byte_w[3:1] == `BWP_SEL_CLEAR;
   wire blk_free = |(blk_mask(byte_w[3:1]) & ~flags);

   bwp_flag_store u_store (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .init_flags_in(init_flags_in),
      .load_init_in(~init_done_q),
      .commit_in(commit_q),
      .clear_all_in(is_clear_q),
      .set_mask_in(mask_q),
      .flags_out(flags)
   );

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         hv_s_q <= 2'h0;
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         ack_phase_q <= 1'b0;
         ack_give_q <= 1'b0;
         dummy_cnt_q <= 2'h0;
         is_clear_q <= 1'b0;
         mask_q <= 4'h0;
         armed_q <= 1'b0;
         hv_ok_q <= 1'b0;
         wr_cnt_q <= 32'h0;
         init_done_q <= 1'b0;
         commit_q <= 1'b0;
         sda_out <= 1'b1;
         sda_oe_n_out <= 1'b1;
         protect_flags_out <= 4'h0;
         addr_protected_out <= 1'b0;
         write_busy_out <= 1'b0;
      end else if (ce_in) begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         hv_s_q <= {hv_s_q[0], high_voltage_level_in};
         scl_d1_q <= scl_s_q[1];
         sda_d1_q <= sda_s_q[1];
         init_done_q <= 1'b1;
         commit_q <= 1'b0;
         protect_flags_out <= flags;
         addr_protected_out <= flags[array_addr_in[8:7]];
         write_busy_out <= busy;
         // self-timed write cycle; flags commit on its last count
         if (busy) begin
            wr_cnt_q <= wr_cnt_q - 32'h1;
            if (wr_cnt_q == 32'h1) begin
               commit_q <= 1'b1;
            end
         end
         // losing high voltage after the control byte and before the stop cancels a pending write; a started write cycle still runs
         if (!hv_s_q[1]) begin
            hv_ok_q <= 1'b0;
         end
         if (start_c || stop_c) begin
            if (stop_c && armed_q && hv_ok_q && dummy_cnt_q == `BWP_DUMMY_BYTES && !busy) begin
               wr_cnt_q <= WR_LOAD;
            end
            armed_q <= 1'b0;
            dummy_cnt_q <= 2'h0;
            bit_cnt_q <= 4'h0;
            ack_phase_q <= 1'b0;
            sda_oe_n_out <= 1'b1;
            state_q <= start_c ? ST_CTRL : ST_IDLE;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_oe_n_out <= 1'b1;
               end
               ST_CTRL, ST_DUMMY: begin
                  if (scl_rise && !ack_phase_q) begin
                     shift_q <= byte_w;
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q == 4'h7) begin
                        ack_phase_q <= 1'b1;
                        if (state_q == ST_CTRL) begin
                           // latched only while idle so a command during the write cannot retarget it
                           if (!busy) begin
                              mask_q <= blk_mask(byte_w[3:1]);
                              is_clear_q <= sel_clear;
                           end
                           hv_ok_q <= hv_s_q[1];
                           if (!code_ok || busy) begin
                              ack_give_q <= 1'b0;
                           end else if (byte_w[0]) begin
                              ack_give_q <= blk_free;
                           end else if (sel_clear) begin
                              ack_give_q <= hv_s_q[1];
                           end else begin
                              ack_give_q <= hv_s_q[1] & blk_free;
                           end
                        end else begin
                           ack_give_q <= armed_q & ~busy & (dummy_cnt_q < `BWP_DUMMY_BYTES);
                        end
                     end
                  end else if (scl_fall && ack_phase_q && bit_cnt_q == 4'h8) begin
                     sda_out <= 1'b0;
                     sda_oe_n_out <= ~ack_give_q;
                     bit_cnt_q <= 4'h9;
                     if (state_q == ST_CTRL) begin
                        armed_q <= ack_give_q & ~shift_q[0];
                     end else if (dummy_cnt_q == `BWP_DUMMY_BYTES) begin
                        dummy_cnt_q <= 2'h3;
                     end else if (ack_give_q) begin
                        dummy_cnt_q <= dummy_cnt_q + 2'h1;
                     end
                  end else if (scl_fall && ack_phase_q) begin
                     sda_oe_n_out <= 1'b1;
                     ack_phase_q <= 1'b0;
                     bit_cnt_q <= 4'h0;
                     if (state_q == ST_CTRL && shift_q[0]) begin
                        state_q <= ST_QUERY;
                     end else begin
                        state_q <= ST_DUMMY;
                     end
                  end
               end
               ST_QUERY: begin
                  sda_oe_n_out <= 1'b1;
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // bwp_protect_ctrl

/* File: tb/bwp_i2c_master.sv */
`timescale 1ns/1ps
module bwp_i2c_master (
   output logic scl_out,
   output logic sda_rel_out,
   input wire logic sda_in
);
   logic ack_seen;
   event ack_ev;
   initial begin
      scl_out = 1'b1;
      sda_rel_out = 1'b1;
   end
   task automatic start();
      sda_rel_out = 1'b0;
      #40 scl_out = 1'b0;
      #40;
   endtask
   // msb first, ninth slot released; a read is ff with nack
   task automatic xbyte(input logic [7:0] b);
      logic [8:0] v;
      v = {b, 1'b1};
      for (int i = 8; i >= 0; i--) begin
         sda_rel_out = v[i];
         #40 scl_out = 1'b1;
         #60 ack_seen = sda_in;
         #20 scl_out = 1'b0;
         #40;
      end
      -> ack_ev;
   endtask
   task automatic stop();
      sda_rel_out = 1'b0;
      #40 scl_out = 1'b1;
      #40 sda_rel_out = 1'b1;
      #80;
   endtask
endmodule // bwp_i2c_master

/* File: tb/bwp_protect_monitor.sv */
`timescale 1ns/1ps
module bwp_protect_monitor #(parameter int WRITE_CYCLES = 200) (
   input wire mclk_in,
   input wire rst_n_in,
   input wire sda_out,
   input wire sda_oe_n_out,
   input wire [8:0] array_addr_in,
   input wire [3:0] protect_flags_out,
   input wire addr_protected_out,
   input wire write_busy_out
);
   localparam int WLO = WRITE_CYCLES - 8;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   a_busy_no_ack: assert property (write_busy_out |-> sda_oe_n_out) else $error("ack in write");
   a_ack_low: assert property (!sda_oe_n_out |-> !sda_out) else $error("ack not low");
   a_ack_hold: assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*6]) else $error("ack short");
   a_busy_min: assert property ($rose(write_busy_out) |-> write_busy_out [*8]) else $error("busy short");
   a_busy_len: assert property ($rose(write_busy_out) |-> ##WLO write_busy_out ##[1:16] !write_busy_out)
      else $error("busy length");
   a_flags_hold: assert property (write_busy_out |-> $stable(protect_flags_out)) else $error("flags moved");
   a_clear_whole: assert property ((($past(protect_flags_out) & ~protect_flags_out) != 4'h0) |->
      protect_flags_out == 4'h0) else $error("partial clear");
   a_addr_flag: assert property (($stable(array_addr_in) && $stable(protect_flags_out)) [*3] |->
      addr_protected_out == protect_flags_out[array_addr_in[8:7]]) else $error("addr flag");
   c_write: cover property ($rose(write_busy_out));
   c_ack: cover property ($fell(sda_oe_n_out));
   c_prot: cover property (addr_protected_out);
endmodule // bwp_protect_monitor
bind bwp_protect_ctrl bwp_protect_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon_u (.mclk_in(mclk_in),
   .rst_n_in(rst_n_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .array_addr_in(array_addr_in),
   .protect_flags_out(protect_flags_out), .addr_protected_out(addr_protected_out), .write_busy_out(write_busy_out));

/* File: tb/test_bwp_protect_ctrl.sv */
`timescale 1ns/1ps
`include "bwp_defs.vh"
module test_bwp_protect_ctrl;
   localparam int WC = 200;
   logic mclk_in = 1'b0, rst_n_in = 1'b0, hv = 1'b1;
   logic [3:0] init_q = 4'h0, ef = 4'h0;
   logic [8:0] addr = 9'h000;
   logic [31:0] seed = 32'd22;
   logic [2:0] sel_t [4] = '{`BWP_SEL_BLK0, `BWP_SEL_BLK1, `BWP_SEL_BLK2, `BWP_SEL_BLK3};
   int n_errors = 0, check_count = 0;
   logic exp_q[$];
   logic [3:0] fq[$];
   wire scl, sda_m, sda_o, oe_n, busy, aprot;
   wire [3:0] flags;
   wire sda = sda_m & (oe_n | sda_o);
   always #10 mclk_in = ~mclk_in;
   bwp_i2c_master m_u (.scl_out(scl), .sda_rel_out(sda_m), .sda_in(sda));
   bwp_protect_ctrl #(.WRITE_CYCLES(WC)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .scl_in(scl),
      .sda_in(sda), .high_voltage_level_in(hv), .init_flags_in(init_q), .array_addr_in(addr), .sda_out(sda_o),
      .sda_oe_n_out(oe_n), .protect_flags_out(flags), .addr_protected_out(aprot), .write_busy_out(busy));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [3:0] e, input logic [3:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic conclude();
      if (fq.size() != 0 || exp_q.size() != 0) begin
         n_errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, 0, fq.size() + exp_q.size());
      end
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(m_u.ack_ev) chk(exp_q.pop_front(), m_u.ack_seen);
   always @(negedge busy) begin
      logic [3:0] e;
      if (rst_n_in) begin
         e = fq.pop_front();
         repeat (3) @(negedge mclk_in);
         chk(e, flags);
         @(posedge mclk_in);
         #5;
         chk(e[addr[8:7]], aprot);
      end
   end
   initial forever begin
      repeat (8) @(negedge mclk_in);
      addr = 9'(rnd());
   end
   initial begin
      #600000;
      n_errors++;
      conclude();
   end
   task automatic cmd(input logic [2:0] sel, input logic rd, input int nd, input logic ea);
      m_u.start();
      exp_q.push_back(ea);
      m_u.xbyte({`BWP_CTRL_CODE, sel, rd});
      repeat (nd) begin
         exp_q.push_back(rd | ea);
         m_u.xbyte(rd ? 8'hff : 8'(rnd()));
      end
      m_u.stop();
   endtask
   task automatic setb(input int n, input int nd, input logic h);
      logic ea;
      hv = h;
      ea = ef[n] | ~h;
      if (!ea && nd == 2) begin
         ef[n] = 1'b1;
         fq.push_back(ef);
      end
      cmd(sel_t[n], 1'b0, nd, ea);
   endtask
   task automatic qry(input int n);
      hv = 1'(rnd());
      cmd(sel_t[n], 1'b1, 1, ef[n]);
   endtask
   task automatic settle();
      repeat (WC + 60) @(negedge mclk_in);
   endtask
   task automatic rst(input logic [3:0] f);
      init_q = f;
      ef = f;
      rst_n_in = 1'b0;
      repeat (12) @(negedge mclk_in);
      rst_n_in = 1'b1;
      repeat (8) @(negedge mclk_in);
   endtask
   initial begin
      rst(4'h0);
      for (int n = 0; n < 4; n++) qry(n);
      $display("test query done");
      setb(0, 2, 1'b1);
      cmd(sel_t[1], 1'b1, 1, 1'b1);
      settle();
      setb(0, 2, 1'b1);
      setb(2, 1, 1'b1);
      setb(3, 2, 1'b0);
      cmd(`BWP_SEL_CLEAR, 1'b0, 2, 1'b1);
      settle();
      $display("test refuse done");
      for (int n = 1; n < 4; n++) begin
         setb(n, 2, 1'b1);
         settle();
         qry(n - 1);
      end
      ef = 4'h0;
      fq.push_back(ef);
      hv = 1'b1;
      cmd(`BWP_SEL_CLEAR, 1'b0, 2, 1'b0);
      settle();
      $display("test set clear done");
      rst(4'ha);
      for (int n = 0; n < 4; n++) qry(n);
      $display("test reload done");
      conclude();
   end
endmodule // test_bwp_protect_ctrl
